// ### seig_pkg.sv
// Purpose: constants for the system event interrupt group
// Assumes: apb with 32-bit data, byte addresses = 4 * register index
// Notes: each of five events keeps one bit position, the same in status, mask and level registers
`default_nettype none
package seig_pkg;
  localparam int unsigned NUM_EVENTS = 5;
  localparam logic [7:0] STATUS_INDEX = 8'h28;
  localparam logic [7:0] MASK_INDEX = 8'h29;
  localparam logic [7:0] LEVEL_INDEX = 8'h2a;
  localparam logic [9:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};
  localparam logic [9:0] MASK_ADDR = {MASK_INDEX, 2'b00};
  localparam logic [9:0] LEVEL_ADDR = {LEVEL_INDEX, 2'b00};
  localparam int unsigned WAKE_BIT = 0;
  localparam int unsigned SLEEP_BIT = 1;
  localparam int unsigned BUTTON_BIT = 2;
  localparam int unsigned UNDERVOLT_BIT = 3;
  localparam int unsigned OVERVOLT_BIT = 4;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [4:0] MASK_RESET = 5'h1f;
endpackage
`default_nettype wire

// ### seig_top.sv
// Purpose: system event interrupt group with apb register access
// Assumes: event inputs are asynchronous levels; mclk 20 MHz
// Notes: a read or a one-write clears status; set wins over clear
//
// Functional notes
// - wake transition done sets status bit 0
// - sleep transition done sets status bit 1
// - button event sets status bit 2
// - undervolt threshold crossing sets status bit 3
// - overvolt threshold crossing sets status bit 4
// - flags reset 0, sticky, read or w1c clears
// - masks reset 1, masked flags keep pin high
// - unmasked set flag pulls interrupt pin low
// - masks read/write, asynchronously forced to masked
// - level bit 0 shows wake in progress
// - level bit 1 shows sleep in progress
// - level bit 2 shows live button pin
// - level bit 3 high below undervolt threshold
// - level bit 4 high above overvolt threshold
`default_nettype none
module seig_top
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic mask_force_n,
  input wire logic wake_in_progress,
  input wire logic sleep_in_progress,
  input wire logic power_button_pin,
  input wire logic undervolt_level,
  input wire logic overvolt_level,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_out_n
);
  localparam int unsigned N = seig_pkg::NUM_EVENTS;

  logic [N-1:0] sync_meta;
  logic [N-1:0] sync_level;
  logic [N-1:0] level_prev;
  logic [N-1:0] status;
  logic [N-1:0] mask;
  logic [N-1:0] raw_in;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic [N-1:0] event_hit;
  logic [N-1:0] clear_hit;
  logic [N-1:0] next_status;
  logic [N-1:0] pending;
  logic access;
  logic aligned;
  logic sel_status;
  logic sel_mask;
  logic sel_level;
  logic mapped;
  logic [N-1:0] read_value;
  logic [31:0] next_prdata;
  logic next_irq_n;
  logic mask_reset_n;

  // target is already a byte address, so the whole bus address is compared
  function automatic logic addr_is(input logic [11:0] a, input logic [9:0] target);
    addr_is = (a == {2'b00, target});
  endfunction

  // event bits assembled in register bit order
  assign raw_in[seig_pkg::WAKE_BIT] = wake_in_progress;
  assign raw_in[seig_pkg::SLEEP_BIT] = sleep_in_progress;
  assign raw_in[seig_pkg::BUTTON_BIT] = power_button_pin;
  assign raw_in[seig_pkg::UNDERVOLT_BIT] = undervolt_level;
  assign raw_in[seig_pkg::OVERVOLT_BIT] = overvolt_level;

  // two flops before any logic sees the pins; first flop feeds only the second
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_meta <= '0;
      sync_level <= '0;
      level_prev <= '0;
    end
    else
    begin
      sync_meta <= raw_in;
      sync_level <= sync_meta;
      level_prev <= sync_level;
    end
  end

  assign rise = sync_level & ~level_prev;
  assign fall = ~sync_level & level_prev;

  // transitions complete when the in-progress level falls
  assign event_hit[seig_pkg::WAKE_BIT] = fall[seig_pkg::WAKE_BIT];
  assign event_hit[seig_pkg::SLEEP_BIT] = fall[seig_pkg::SLEEP_BIT];
  // button press or release both count as an event
  assign event_hit[seig_pkg::BUTTON_BIT] = rise[seig_pkg::BUTTON_BIT]
    | fall[seig_pkg::BUTTON_BIT];
  // threshold crossing in either direction
  assign event_hit[seig_pkg::UNDERVOLT_BIT] = rise[seig_pkg::UNDERVOLT_BIT]
    | fall[seig_pkg::UNDERVOLT_BIT];
  assign event_hit[seig_pkg::OVERVOLT_BIT] = rise[seig_pkg::OVERVOLT_BIT]
    | fall[seig_pkg::OVERVOLT_BIT];

  // apb decode; zero wait states
  assign access = psel && penable;
  assign sel_status = addr_is(paddr, seig_pkg::STATUS_ADDR);
  assign sel_mask = addr_is(paddr, seig_pkg::MASK_ADDR);
  assign sel_level = addr_is(paddr, seig_pkg::LEVEL_ADDR);
  assign aligned = paddr[1:0] == 2'b00;
  assign mapped = aligned && (sel_status || sel_mask || sel_level);

  // read clears every bit status holds in access, including any set after setup; write clears bits written as one
  assign clear_hit = (access && sel_status && !pwrite) ? status
    : (access && sel_status && pwrite && pstrb[0]) ? pwdata[N-1:0]
    : '0;
  // set wins over a clear in the same cycle
  assign next_status = (status & ~clear_hit) | event_hit;

  assign read_value = sel_status ? status
    : sel_mask ? mask
    : sel_level ? sync_level
    : '0;
  assign next_prdata = (psel && !penable && !pwrite && mapped)
    ? {{(32 - N){1'b0}}, read_value} : prdata;

  assign pending = status & ~mask;
  assign next_irq_n = ~|pending;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      status <= seig_pkg::STATUS_RESET;
    else
      status <= next_status;
  end

  // masks also jump to masked on the asynchronous force
  assign mask_reset_n = reset_n & mask_force_n;

  always_ff @(posedge mclk or negedge mask_reset_n)
  begin
    if (!mask_reset_n)
      mask <= seig_pkg::MASK_RESET;
    else if (access && pwrite && sel_mask && pstrb[0])
      mask <= pwdata[N-1:0];
  end

  // read data latched in setup so the clear in access cannot alter it
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
      irq_out_n <= 1'b1;
      pready <= 1'b1;
    end
    else
    begin
      prdata <= next_prdata;
      pslverr <= psel && !penable && !mapped;
      irq_out_n <= next_irq_n;
      // zero wait states, but kept in a flop so every output is registered
      pready <= 1'b1;
    end
  end

  // assertions
  a_flag_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
    (status[0] && !clear_hit[0]) |=> status[0])
    else $error("status flag dropped without clear");
  a_read_clears: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && !pwrite && sel_status && event_hit == '0) |=> status == '0)
    else $error("status not cleared by read");
  a_mask_blocks: assert property (@(posedge mclk) disable iff (!reset_n)
    (mask == 5'h1f) [*2] |=> irq_out_n)
    else $error("pin low while fully masked");
  a_irq_follows: assert property (@(posedge mclk) disable iff (!reset_n)
    (|(status & ~mask)) |=> !irq_out_n)
    else $error("pin not low for pending event");
  a_irq_release: assert property (@(posedge mclk) disable iff (!reset_n)
    !(|(status & ~mask)) |=> irq_out_n)
    else $error("pin held low with nothing pending");
  a_wake_done: assert property (@(posedge mclk) disable iff (!reset_n)
    (level_prev[0] && !sync_level[0]) |=> status[0])
    else $error("wake completion not flagged");
  a_sleep_done: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(sync_level[1]) |=> status[1])
    else $error("sleep completion not flagged");
  a_button_edge: assert property (@(posedge mclk) disable iff (!reset_n)
    (sync_level[2] != level_prev[2]) |=> status[2])
    else $error("button event not flagged");
  a_crossing_set: assert property (@(posedge mclk) disable iff (!reset_n)
    (sync_level[4:3] != level_prev[4:3]) |=> (status[4:3] & $past(sync_level[4:3]
      ^ level_prev[4:3])) == $past(sync_level[4:3] ^ level_prev[4:3]))
    else $error("threshold crossing not flagged");
  a_no_level_set: assert property (@(posedge mclk) disable iff (!reset_n)
    (event_hit == '0 && clear_hit == status) |=> status == '0)
    else $error("flag set by a steady level");
  a_mask_write: assert property (@(posedge mclk) disable iff (!mask_reset_n)
    (access && pwrite && sel_mask && pstrb[0]) |=> mask == $past(pwdata[4:0]))
    else $error("mask write lost");

  // per event: edge sets, nothing else sets, read and one-write clear
  a_wake_set: assert property (@(posedge mclk) disable iff (!reset_n)
    event_hit[0] |=> status[0])
    else $error("wake event did not set flag");
  a_wake_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    (!status[0] && !event_hit[0]) |=> !status[0])
    else $error("wake flag set without edge");
  a_wake_level: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && !penable && !pwrite && sel_level) |=> prdata[0] == $past(sync_level[0]))
    else $error("wake level read wrong");
  a_wake_w1c: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && pwrite && sel_status && pstrb[0] && pwdata[0] && !event_hit[0]) |=> !status[0])
    else $error("wake flag not cleared by write");
  a_wake_rdclr: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && !pwrite && sel_status && !event_hit[0]) |=> !status[0])
    else $error("wake flag not cleared by read");
  a_wake_unmask: assert property (@(posedge mclk) disable iff (!reset_n)
    (status[0] && !mask[0]) |=> !irq_out_n)
    else $error("unmasked wake flag did not pull pin");

  a_sleep_set: assert property (@(posedge mclk) disable iff (!reset_n)
    event_hit[1] |=> status[1])
    else $error("sleep event did not set flag");
  a_sleep_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    (status[1] && !clear_hit[1]) |=> status[1])
    else $error("sleep flag dropped without clear");
  a_sleep_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    (!status[1] && !event_hit[1]) |=> !status[1])
    else $error("sleep flag set without edge");
  a_sleep_level: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && !penable && !pwrite && sel_level) |=> prdata[1] == $past(sync_level[1]))
    else $error("sleep level read wrong");
  a_sleep_w1c: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && pwrite && sel_status && pstrb[0] && pwdata[1] && !event_hit[1]) |=> !status[1])
    else $error("sleep flag not cleared by write");
  a_sleep_rdclr: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && !pwrite && sel_status && !event_hit[1]) |=> !status[1])
    else $error("sleep flag not cleared by read");
  a_sleep_unmask: assert property (@(posedge mclk) disable iff (!reset_n)
    (status[1] && !mask[1]) |=> !irq_out_n)
    else $error("unmasked sleep flag did not pull pin");

  a_button_set: assert property (@(posedge mclk) disable iff (!reset_n)
    event_hit[2] |=> status[2])
    else $error("button event did not set flag");
  a_button_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    (status[2] && !clear_hit[2]) |=> status[2])
    else $error("button flag dropped without clear");
  a_button_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    (!status[2] && !event_hit[2]) |=> !status[2])
    else $error("button flag set without edge");
  a_button_level: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && !penable && !pwrite && sel_level) |=> prdata[2] == $past(sync_level[2]))
    else $error("button level read wrong");
  a_button_w1c: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && pwrite && sel_status && pstrb[0] && pwdata[2] && !event_hit[2]) |=> !status[2])
    else $error("button flag not cleared by write");
  a_button_rdclr: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && !pwrite && sel_status && !event_hit[2]) |=> !status[2])
    else $error("button flag not cleared by read");
  a_button_unmask: assert property (@(posedge mclk) disable iff (!reset_n)
    (status[2] && !mask[2]) |=> !irq_out_n)
    else $error("unmasked button flag did not pull pin");

  a_under_set: assert property (@(posedge mclk) disable iff (!reset_n)
    event_hit[3] |=> status[3])
    else $error("undervolt crossing did not set flag");
  a_under_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    (status[3] && !clear_hit[3]) |=> status[3])
    else $error("undervolt flag dropped without clear");
  a_under_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    (!status[3] && !event_hit[3]) |=> !status[3])
    else $error("undervolt flag set without edge");
  a_under_level: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && !penable && !pwrite && sel_level) |=> prdata[3] == $past(sync_level[3]))
    else $error("undervolt level read wrong");
  a_under_w1c: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && pwrite && sel_status && pstrb[0] && pwdata[3] && !event_hit[3]) |=> !status[3])
    else $error("undervolt flag not cleared by write");
  a_under_rdclr: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && !pwrite && sel_status && !event_hit[3]) |=> !status[3])
    else $error("undervolt flag not cleared by read");
  a_under_unmask: assert property (@(posedge mclk) disable iff (!reset_n)
    (status[3] && !mask[3]) |=> !irq_out_n)
    else $error("unmasked undervolt flag did not pull pin");

  a_over_set: assert property (@(posedge mclk) disable iff (!reset_n)
    event_hit[4] |=> status[4])
    else $error("overvolt crossing did not set flag");
  a_over_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    (status[4] && !clear_hit[4]) |=> status[4])
    else $error("overvolt flag dropped without clear");
  a_over_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    (!status[4] && !event_hit[4]) |=> !status[4])
    else $error("overvolt flag set without edge");
  a_over_level: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && !penable && !pwrite && sel_level) |=> prdata[4] == $past(sync_level[4]))
    else $error("overvolt level read wrong");
  a_over_w1c: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && pwrite && sel_status && pstrb[0] && pwdata[4] && !event_hit[4]) |=> !status[4])
    else $error("overvolt flag not cleared by write");
  a_over_rdclr: assert property (@(posedge mclk) disable iff (!reset_n)
    (access && !pwrite && sel_status && !event_hit[4]) |=> !status[4])
    else $error("overvolt flag not cleared by read");
  a_over_unmask: assert property (@(posedge mclk) disable iff (!reset_n)
    (status[4] && !mask[4]) |=> !irq_out_n)
    else $error("unmasked overvolt flag did not pull pin");

  // bus side and mask force
  a_mask_forced: assert property (@(posedge mclk) disable iff (!reset_n)
    !mask_force_n |-> mask == 5'h1f)
    else $error("masks not forced");
  a_mask_stable: assert property (@(posedge mclk) disable iff (!reset_n)
    (mask_force_n && !(access && pwrite && sel_mask && pstrb[0])) ##1 mask_force_n
      |-> $stable(mask))
    else $error("mask changed without write");
  a_status_read: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && !penable && !pwrite && sel_status) |=> prdata[4:0] == $past(status))
    else $error("status read data wrong");
  a_prdata_upper: assert property (@(posedge mclk) disable iff (!reset_n)
    prdata[31:5] == 27'h000_0000)
    else $error("unused read bits not zero");
  a_unmapped_err: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && !penable && !mapped) |=> pslverr)
    else $error("unmapped access without error");
  a_ready_high: assert property (@(posedge mclk) disable iff (!reset_n)
    pready)
    else $error("ready low");
endmodule
`default_nettype wire

// ### seig_env.sv
// Purpose: far-side event source model
// Assumes: levels are commanded by the bench
// Notes: levels move only after a clock edge, never mid-cycle
`default_nettype none
module seig_env
(
  input wire logic mclk,
  input wire logic [4:0] cmd,
  output logic [4:0] lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  initial lvl = 5'h00;
  always @(posedge mclk) lvl <= cmd;
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: register level bench for the event interrupt group
// Assumes: pready is polled though it answers at once
// Notes: six edges let an event pass the input synchronisers
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic mclk = 0, reset_n = 0, mask_force_n = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = ZERO, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [4:0] cmd = 5'h00, lvl;
  logic pready, pslverr, irq_out_n, err;
  int n_fail = 0, checks = 0, cyc = 0;
  initial forever #25 mclk = ~mclk;
  seig_env u_seig_env (.mclk(mclk), .cmd(cmd), .lvl(lvl));
  seig_top u_seig_top (.mclk(mclk), .reset_n(reset_n), .mask_force_n(mask_force_n),
    .wake_in_progress(lvl[0]), .sleep_in_progress(lvl[1]), .power_button_pin(lvl[2]),
    .undervolt_level(lvl[3]), .overvolt_level(lvl[4]), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_out_n(irq_out_n));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // read data and error are taken at the pready edge only
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, a};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    xfer(1'b0, seig_pkg::MASK_ADDR, ZERO);
    check("mask reset", rd, 32'h0000_001f);
    xfer(1'b0, seig_pkg::STATUS_ADDR, ZERO);
    check("status reset", rd, ZERO);
    for (int i = 0; i < 5; i++)
    begin
      cmd <= 5'h01 << i;
      repeat (6) @(posedge mclk);
      xfer(1'b0, seig_pkg::LEVEL_ADDR, ZERO);
      check("level", rd, ONE << i);
      xfer(1'b0, seig_pkg::STATUS_ADDR, ZERO);
      check("status rise", rd, (i < 2) ? ZERO : ONE << i);
      xfer(1'b0, seig_pkg::STATUS_ADDR, ZERO);
      check("status cleared", rd, ZERO);
      cmd <= 5'h00;
      repeat (6) @(posedge mclk);
      xfer(1'b0, seig_pkg::STATUS_ADDR, ZERO);
      check("status fall", rd, ONE << i);
      check("irq masked", 32'(irq_out_n), ONE);
    end
    cmd <= 5'h04;
    repeat (6) @(posedge mclk);
    xfer(1'b1, seig_pkg::MASK_ADDR, 32'h0000_001b);
    xfer(1'b0, seig_pkg::MASK_ADDR, ZERO);
    check("mask rw", rd, 32'h0000_001b);
    check("irq low", 32'(irq_out_n), ZERO);
    xfer(1'b1, seig_pkg::STATUS_ADDR, 32'h0000_0004);
    repeat (2) @(posedge mclk);
    check("irq released", 32'(irq_out_n), ONE);
    mask_force_n <= 1'b0;
    @(posedge mclk);
    mask_force_n <= 1'b1;
    xfer(1'b0, seig_pkg::MASK_ADDR, ZERO);
    check("mask forced", rd, 32'h0000_001f);
    xfer(1'b0, 10'h0ac, ZERO);
    check("unmapped error", 32'(err), ONE);
    final_report();
  end
endmodule
`default_nettype wire
